// File: common/scef_pkg.sv
`default_nettype none
package scef_pkg;
   // Register bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int EVT_W = 8;
   localparam int TMR_W = 16;
   localparam int LEN_W = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0c;
   localparam logic [7:0] OFS_TERMCHAR = 8'h10;
   localparam logic [7:0] OFS_TIMEOUT = 8'h14;
   localparam logic [7:0] OFS_LENLIMIT = 8'h18;
   localparam logic [7:0] OFS_COMMAND = 8'h1c;

   // Event flag positions, shared between modes
   localparam int BIT_TERM = 7;
   localparam int BIT_START_TIME = 6;
   localparam int BIT_REMOTE_PAR = 5;
   localparam int BIT_PROT_FRM_SYNC = 4;
   localparam int BIT_LOCK = 3;
   localparam int BIT_CARRIER = 2;
   localparam int BIT_OVERFLOW = 1;
   localparam int BIT_LENGTH = 0;

   // Configuration fields
   localparam int CFG_MODE_LO = 0;
   localparam int CFG_AUTO = 2;
   localparam int CFG_ADDR_RECOG = 3;
   localparam int CFG_PARITY_EN = 4;
   localparam int CFG_STATUS_BYTE = 5;
   localparam int CFG_VISIBLE = 6;
   localparam int CFG_LEN_CHECK = 7;
   localparam int CFG_TMR_EN = 8;
   localparam int CFG_DPLL_RX = 9;
   localparam int CFG_FM_ENC = 10;
   localparam int CFG_TX_DPLL = 11;
   localparam int CFG_W = 12;

   // Command, state and status byte fields
   localparam int CMD_SYNC_SEARCH_COMMAND = 0;
   localparam int ST_CARRIER = 0;
   localparam int ST_REMOTE_READY = 1;
   localparam int ST_LOCKED = 2;
   localparam int ST_SYNC_SEARCH_COMMAND = 3;
   localparam int SB_PARITY = 0;
   localparam int SB_FRAMING = 1;

   // Values after reset
   localparam logic [EVT_W-1:0] MASK_RST = 8'hff;
   localparam logic [CFG_W-1:0] CONFIG_RST = 12'h000;
   localparam logic [7:0] TERMCHAR_RST = 8'h00;
   localparam logic [TMR_W-1:0] TIMEOUT_RST = 16'h0010;
   localparam logic [LEN_W-1:0] LENLIMIT_RST = 16'h0100;

   // Timeout tick
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      MODE_HDLC = 2'b00,
      MODE_ASYNC = 2'b01,
      MODE_BISYNC = 2'b10,
      MODE_RSVD = 2'b11
   } scef_mode_type;

   function automatic logic scef_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      scef_hit = (addr == ofs);
   endfunction
endpackage
`default_nettype wire

// File: common/scef_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scef_tmr_if;
   import scef_pkg::*;
   logic enable;
   logic restart;
   logic [TMR_W-1:0] limit;
   logic expired;
   modport timer (input enable, input restart, input limit, output expired);
   modport owner (output enable, output restart, output limit, input expired);
endinterface
`default_nettype wire

// File: rtl/scef_idle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module scef_idle_timer
   import scef_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Control from the flag block
   scef_tmr_if.timer tmr
);
   logic [15:0] pre_r;
   logic tick;
   logic [TMR_W-1:0] cnt_r;
   logic armed_r;
   logic expired_r;
   logic reach;

   assign tick = (pre_r == 16'(TICK_CYCLES - 1));
   assign reach = tick && armed_r && (cnt_r + 16'h0001 >= tmr.limit);
   assign tmr.expired = expired_r;

   // Prescaler keeps the counter narrow; resolution is one tick
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pre_r <= 16'h0000;
      end else begin
         pre_r <= tick ? 16'h0000 : pre_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 16'h0000;
         armed_r <= 1'b0;
         expired_r <= 1'b0;
      end else begin
         expired_r <= reach && tmr.enable && !tmr.restart; // [R4]
         if (tmr.restart) begin
            cnt_r <= 16'h0000;
            armed_r <= tmr.enable;
         end else if (reach || !tmr.enable) begin
            armed_r <= 1'b0;
         end else if (tick && armed_r) begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end
endmodule // scef_idle_timer
`default_nettype wire

// File: rtl/scef_event_flags.sv
// Operation
// R1 - Async/bisync: received character equal to termination character sets its flag.
// R2 - Termination character pushes a frame-end marker toward the receive FIFO.
// R3 - HDLC: frame start flagged on address match, or start flag without recognition.
// R4 - Async: idle timeout flagged when no character arrives within programmed period.
// R5 - HDLC auto: RR/RNR changing remote state flagged; state readable.
// R6 - Parity enabled, async/bisync: bad-parity character sets parity fault flag.
// R7 - Status byte option also records parity fault per character.
// R8 - HDLC auto: wrong N(R) or I-field in S-frame flags protocol fault.
// R9 - Async: zero sampled at stop bit sets framing fault flag.
// R10 - Bisync: sync character after sync_search_command command sets sync found flag.
// R11 - DPLL with FM/Manchester receive clock: lock loss sets its flag.
// R12 - Without lock, reception suspended; transmission too when clocked from DPLL.
// R13 - Every carrier detect transition flagged; present level readable.
// R14 - HDLC: frame arriving with receive FIFO full sets overflow flag.
// R15 - Async/bisync: character arriving with FIFO full sets overflow flag.
// R16 - HDLC length check: frame over limit aborted and length flag set.
// R17 - Masked events raise no interrupt; visibility option decides status display.
// R18 - All events masked after reset.
// R19 - Flags stick until acknowledged by status read; new events accumulate.
`timescale 1ns/1ps
`default_nettype none
module scef_event_flags
   import scef_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata,
   // Receive character events
   input wire logic charValid,
   input wire logic [7:0] charData,
   input wire logic charParityBad,
   input wire logic charStopZero,
   input wire logic syncDetect,
   // Receive frame events
   input wire logic startFlag,
   input wire logic addrMatch,
   input wire logic sFrameValid,
   input wire logic sFrameRnr,
   input wire logic nrCountBad,
   input wire logic sFrameIField,
   input wire logic frameArrive,
   input wire logic rxByteValid,
   // Line and FIFO status levels
   input wire logic dpllLocked,
   input wire logic carrierDetectInput,
   input wire logic rxFifoFull,
   // Host side
   output logic hostInterruptLine,
   // Receive and transmit path controls
   output logic frameEndMark,
   output logic charDrop,
   output logic frameAbort,
   output logic statusByteValid,
   output logic [7:0] statusByte,
   output logic rxSuspend,
   output logic txSuspend
);
   logic [EVT_W-1:0] status_r;
   logic [EVT_W-1:0] status_nxt;
   logic [EVT_W-1:0] mask_r;
   logic [CFG_W-1:0] config_r;
   logic [7:0] termChar_r;
   logic [TMR_W-1:0] timeout_r;
   logic [LEN_W-1:0] lenLimit_r;
   logic [DATA_W-1:0] regRdata_r;
   logic hostInterruptLine_r;
   logic frameEndMark_r;
   logic charDrop_r;
   logic frameAbort_r;
   logic statusByteValid_r;
   logic [7:0] statusByte_r;
   logic rxSuspend_r;
   logic txSuspend_r;
   logic remoteReadyState_r;
   logic syncSearch_r;
   logic lockPrev_r;
   logic carrierPrev_r;
   logic [LEN_W-1:0] frameLen_r;
   logic frameAborted_r;

   scef_tmr_if tmrBus ();

   // Mode and option decode
   scef_mode_type mode;
   logic isHdlc;
   logic isAsync;
   logic isBisync;
   logic charMode;
   logic autoMode;
   logic dpllUsed;
   assign mode = scef_mode_type'(config_r[CFG_MODE_LO +: 2]);
   assign isHdlc = (mode == MODE_HDLC);
   assign isAsync = (mode == MODE_ASYNC);
   assign isBisync = (mode == MODE_BISYNC);
   assign charMode = isAsync || isBisync;
   assign autoMode = isHdlc && config_r[CFG_AUTO];
   assign dpllUsed = config_r[CFG_DPLL_RX] && config_r[CFG_FM_ENC];

   // Register access decode
   logic wrMask;
   logic wrConfig;
   logic wrTerm;
   logic wrTimeout;
   logic wrLen;
   logic wrCmd;
   logic rdStatus;
   logic huntCmd;
   assign wrMask = regWr && scef_hit(regAddr, OFS_MASK);
   assign wrConfig = regWr && scef_hit(regAddr, OFS_CONFIG);
   assign wrTerm = regWr && scef_hit(regAddr, OFS_TERMCHAR);
   assign wrTimeout = regWr && scef_hit(regAddr, OFS_TIMEOUT);
   assign wrLen = regWr && scef_hit(regAddr, OFS_LENLIMIT);
   assign wrCmd = regWr && scef_hit(regAddr, OFS_COMMAND);
   assign rdStatus = regRd && scef_hit(regAddr, OFS_STATUS);
   assign huntCmd = wrCmd && regWdata[CMD_SYNC_SEARCH_COMMAND];

   // Individual events
   logic evTerm;
   logic evStart;
   logic evTime;
   logic evRemote;
   logic evParity;
   logic evProtocol;
   logic evFraming;
   logic evSync;
   logic evLock;
   logic evCarrier;
   logic evOverflow;
   logic evLength;
   logic remoteNext;
   logic lenOver;
   assign evTerm = charMode && charValid && (charData == termChar_r); // [R1]
   assign evStart = isHdlc && (config_r[CFG_ADDR_RECOG] ? addrMatch : startFlag); // [R3]
   assign evTime = isAsync && tmrBus.expired; // [R4]
   assign remoteNext = !sFrameRnr;
   assign evRemote = autoMode && sFrameValid && (remoteNext != remoteReadyState_r); // [R5]
   assign evParity = charMode && config_r[CFG_PARITY_EN] && charValid && charParityBad; // [R6]
   assign evProtocol = autoMode && ((sFrameValid && nrCountBad) || sFrameIField); // [R8]
   assign evFraming = isAsync && charValid && charStopZero; // [R9]
   assign evSync = isBisync && syncSearch_r && syncDetect; // [R10]
   assign evLock = dpllUsed && lockPrev_r && !dpllLocked; // [R11]
   assign evCarrier = carrierDetectInput != carrierPrev_r; // [R13]
   assign evOverflow = (isHdlc && frameArrive && rxFifoFull) // [R14]
                    || (charMode && charValid && rxFifoFull); // [R15]
   assign lenOver = rxByteValid && (frameLen_r >= lenLimit_r) && !frameAborted_r;
   assign evLength = isHdlc && config_r[CFG_LEN_CHECK] && lenOver; // [R16]

   // Shared bit positions carry the event of the selected mode
   logic [EVT_W-1:0] evVec;
   logic [EVT_W-1:0] shownVec;
   always_comb begin
      evVec = '0;
      evVec[BIT_TERM] = evTerm;
      evVec[BIT_START_TIME] = evStart || evTime;
      evVec[BIT_REMOTE_PAR] = evRemote || evParity;
      evVec[BIT_PROT_FRM_SYNC] = evProtocol || evFraming || evSync;
      evVec[BIT_LOCK] = evLock;
      evVec[BIT_CARRIER] = evCarrier;
      evVec[BIT_OVERFLOW] = evOverflow;
      evVec[BIT_LENGTH] = evLength;
   end

   // Masked events only reach the status register when visibility is on
   assign shownVec = evVec & (~mask_r | {EVT_W{config_r[CFG_VISIBLE]}}); // [R17]
   // A status read clears what it returned; an event in the same cycle wins
   assign status_nxt = (status_r & ~({EVT_W{rdStatus}} & status_r)) | shownVec; // [R19]

   // Read multiplexer
   logic [DATA_W-1:0] rdMux;
   logic [DATA_W-1:0] stateWord;
   assign stateWord = {28'h0000000, syncSearch_r, dpllLocked, remoteReadyState_r, carrierDetectInput}; // [R5] [R13]
   always_comb begin
      if (scef_hit(regAddr, OFS_STATUS)) begin
         rdMux = {24'h000000, status_r};
      end else if (scef_hit(regAddr, OFS_MASK)) begin
         rdMux = {24'h000000, mask_r};
      end else if (scef_hit(regAddr, OFS_CONFIG)) begin
         rdMux = {20'h00000, config_r};
      end else if (scef_hit(regAddr, OFS_STATE)) begin
         rdMux = stateWord;
      end else if (scef_hit(regAddr, OFS_TERMCHAR)) begin
         rdMux = {24'h000000, termChar_r};
      end else if (scef_hit(regAddr, OFS_TIMEOUT)) begin
         rdMux = {16'h0000, timeout_r};
      end else if (scef_hit(regAddr, OFS_LENLIMIT)) begin
         rdMux = {16'h0000, lenLimit_r};
      end else begin
         rdMux = 32'h00000000;
      end
   end

   // Software registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mask_r <= MASK_RST; // [R18]
         config_r <= CONFIG_RST;
         termChar_r <= TERMCHAR_RST;
         timeout_r <= TIMEOUT_RST;
         lenLimit_r <= LENLIMIT_RST;
      end else begin
         if (wrMask) mask_r <= regWdata[EVT_W-1:0];
         if (wrConfig) config_r <= regWdata[CFG_W-1:0];
         if (wrTerm) termChar_r <= regWdata[7:0];
         if (wrTimeout) timeout_r <= regWdata[TMR_W-1:0];
         if (wrLen) lenLimit_r <= regWdata[LEN_W-1:0];
      end
   end

   // Flags, interrupt line and read data
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         status_r <= '0;
         hostInterruptLine_r <= 1'b0;
         regRdata_r <= 32'h00000000;
      end else begin
         status_r <= status_nxt; // [R19]
         hostInterruptLine_r <= |(status_r & ~mask_r); // [R17]
         regRdata_r <= regRd ? rdMux : 32'h00000000;
      end
   end

   // Line state tracking
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         remoteReadyState_r <= 1'b1;
         syncSearch_r <= 1'b0;
         lockPrev_r <= 1'b0;
         carrierPrev_r <= 1'b0;
      end else begin
         if (autoMode && sFrameValid) remoteReadyState_r <= remoteNext; // [R5]
         if (huntCmd) begin
            syncSearch_r <= 1'b1;
         end else if (evSync) begin
            syncSearch_r <= 1'b0; // [R10]
         end
         lockPrev_r <= dpllLocked;
         carrierPrev_r <= carrierDetectInput;
      end
   end

   // Frame length tracking; a new start flag rearms the check
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frameLen_r <= '0;
         frameAborted_r <= 1'b0;
      end else if (startFlag) begin
         frameLen_r <= '0;
         frameAborted_r <= 1'b0;
      end else if (evLength) begin
         frameAborted_r <= 1'b1; // [R16]
      end else if (rxByteValid && !frameAborted_r && frameLen_r != {LEN_W{1'b1}}) begin
         frameLen_r <= frameLen_r + 16'h0001;
      end
   end

   // Receive and transmit path controls
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frameEndMark_r <= 1'b0;
         charDrop_r <= 1'b0;
         frameAbort_r <= 1'b0;
         statusByteValid_r <= 1'b0;
         statusByte_r <= 8'h00;
         rxSuspend_r <= 1'b0;
         txSuspend_r <= 1'b0;
      end else begin
         frameEndMark_r <= evTerm; // [R2]
         charDrop_r <= charMode && charValid && rxFifoFull; // [R15]
         frameAbort_r <= evLength; // [R16]
         statusByteValid_r <= charMode && charValid && config_r[CFG_STATUS_BYTE];
         statusByte_r <= 8'h00;
         statusByte_r[SB_PARITY] <= evParity && config_r[CFG_STATUS_BYTE]; // [R7]
         statusByte_r[SB_FRAMING] <= evFraming && config_r[CFG_STATUS_BYTE];
         rxSuspend_r <= dpllUsed && !dpllLocked; // [R12]
         txSuspend_r <= dpllUsed && !dpllLocked && config_r[CFG_TX_DPLL]; // [R12]
      end
   end

   // Idle timer restarts on every character while async timeout is enabled
   assign tmrBus.enable = isAsync && config_r[CFG_TMR_EN];
   assign tmrBus.restart = charValid;
   assign tmrBus.limit = timeout_r;

   scef_idle_timer #(
      .TICK_CYCLES(TICK_CYC)
   ) uTimer (
      .mclk(mclk),
      .nrst(nrst),
      .tmr(tmrBus)
   );

   assign regRdata = regRdata_r;
   assign hostInterruptLine = hostInterruptLine_r;
   assign frameEndMark = frameEndMark_r;
   assign charDrop = charDrop_r;
   assign frameAbort = frameAbort_r;
   assign statusByteValid = statusByteValid_r;
   assign statusByte = statusByte_r;
   assign rxSuspend = rxSuspend_r;
   assign txSuspend = txSuspend_r;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   logic visOn;
   assign visOn = config_r[CFG_VISIBLE];

   sequence s_huntCmd;
      huntCmd && isBisync;
   endsequence
   sequence s_syncSeen;
      syncDetect && isBisync && !wrConfig && (!mask_r[BIT_PROT_FRM_SYNC] || visOn);
   endsequence

   property p_term;
      charMode && charValid && (charData == termChar_r) && (!mask_r[BIT_TERM] || visOn)
         |=> status_r[BIT_TERM] && frameEndMark;
   endproperty
   a_term: assert property (p_term) else $error("termination char not flagged"); // [R1] [R2]

   property p_start;
      isHdlc && !config_r[CFG_ADDR_RECOG] && startFlag && (!mask_r[BIT_START_TIME] || visOn)
         |=> status_r[BIT_START_TIME];
   endproperty
   a_start: assert property (p_start) else $error("frame start not flagged"); // [R3]

   property p_sync_search_command;
      s_huntCmd ##1 s_syncSeen |=> status_r[BIT_PROT_FRM_SYNC] && !syncSearch_r;
   endproperty
   a_sync_search_command: assert property (p_sync_search_command) else $error("sync after sync_search_command not flagged"); // [R10]

   property p_lock;
      dpllUsed && $fell(dpllLocked) && !wrConfig
         |=> rxSuspend && (status_r[BIT_LOCK] || ($past(mask_r[BIT_LOCK]) && !visOn));
   endproperty
   a_lock: assert property (p_lock) else $error("lock loss not handled"); // [R11] [R12]

   property p_carrier;
      $changed(carrierDetectInput) && (!mask_r[BIT_CARRIER] || visOn) |=> status_r[BIT_CARRIER];
   endproperty
   a_carrier: assert property (p_carrier) else $error("carrier change not flagged"); // [R13]

   property p_drop;
      charMode && charValid && rxFifoFull && !wrConfig |=> charDrop;
   endproperty
   a_drop: assert property (p_drop) else $error("overflow char not dropped"); // [R15]

   property p_abort;
      evLength |=> frameAbort ##1 !frameAbort;
   endproperty
   a_abort: assert property (p_abort) else $error("length abort not single pulse"); // [R16]

   property p_maskIntr;
      ((status_r & ~mask_r) == 8'h00) |=> !hostInterruptLine;
   endproperty
   a_maskIntr: assert property (p_maskIntr) else $error("interrupt from masked flags"); // [R17]

   property p_sticky;
      status_r[BIT_CARRIER] && !rdStatus |=> status_r[BIT_CARRIER];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost before acknowledge"); // [R19]

   property p_setWins;
      rdStatus && shownVec[BIT_OVERFLOW] |=> status_r[BIT_OVERFLOW];
   endproperty
   a_setWins: assert property (p_setWins) else $error("event lost during clear"); // [R19]

   property p_parityByte;
      evParity && config_r[CFG_STATUS_BYTE] |=> statusByteValid && statusByte[SB_PARITY];
   endproperty
   a_parityByte: assert property (p_parityByte) else $error("parity not in status byte"); // [R6] [R7]
endmodule // scef_event_flags
`default_nettype wire

// File: dv/scef_remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module scef_remote_station (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Request from the bench
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [7:0] data,
   input wire logic [1:0] qual,
   // Receive events toward the block
   output logic [7:0] pulse,
   output logic [7:0] charData,
   output logic [1:0] pulseQual
);
   // Data outside a pulse is inverted so a stale value never looks fresh
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pulse <= 8'h00;
         charData <= 8'h00;
         pulseQual <= 2'b00;
      end else begin
         pulse <= go ? (8'h01 << kind) : 8'h00;
         charData <= go ? data : ~charData;
         pulseQual <= go ? qual : 2'b00;
      end
   end
endmodule // scef_remote_station
`default_nettype wire

// File: dv/test_serial_channel_event_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_channel_event_flags;
   import scef_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [DATA_W-1:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic go = 1'b0;
   logic [2:0] kind = 3'h0;
   logic [7:0] data = 8'h00;
   logic [1:0] qual = 2'b00;
   logic [7:0] pulse;
   logic [7:0] charData;
   logic [1:0] pulseQual;
   logic dpllLocked = 1'b1;
   logic carrier = 1'b0;
   logic fifoFull = 1'b0;
   logic hostInt, frameEndMark, charDrop, frameAbort, sbValid, rxSuspend, txSuspend;
   logic [7:0] statusByte;
   logic [11:0] snap;
   logic [DATA_W-1:0] rdv;
   logic [7:0] term;
   logic [7:0] d;
   logic [1:0] q;
   int err_total = 0;
   int check_count = 0;
   int seed = 32'hf3dbaaa8;

   always #2.5 mclk = ~mclk;

   scef_remote_station i_scef_remote_station (.mclk(mclk), .nrst(nrst), .go(go), .kind(kind), .data(data),
      .qual(qual), .pulse(pulse), .charData(charData), .pulseQual(pulseQual));

   scef_event_flags i_scef_event_flags (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .charValid(pulse[0]), .charData(charData),
      .charParityBad(pulseQual[0]), .charStopZero(pulseQual[1]), .syncDetect(pulse[1]), .startFlag(pulse[2]),
      .addrMatch(pulse[3]), .sFrameValid(pulse[4]), .sFrameRnr(pulseQual[0]), .nrCountBad(pulseQual[1]),
      .sFrameIField(pulse[5]), .frameArrive(pulse[6]), .rxByteValid(pulse[7]), .dpllLocked(dpllLocked),
      .carrierDetectInput(carrier), .rxFifoFull(fifoFull), .hostInterruptLine(hostInt),
      .frameEndMark(frameEndMark), .charDrop(charDrop), .frameAbort(frameAbort), .statusByteValid(sbValid),
      .statusByte(statusByte), .rxSuspend(rxSuspend), .txSuspend(txSuspend));

   // Status expected after one received character
   function automatic logic [31:0] exp_char(input logic [1:0] fq, input logic isTerm);
      exp_char = {24'h0, isTerm, 1'b0, fq[0], fq[1], 4'h0};
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= wd;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      rdv = regRdata;
      chk(name, exp, rdv);
   endtask

   task automatic send(input logic [2:0] k, input logic [7:0] sd, input logic [1:0] sq);
      @(posedge mclk);
      go <= 1'b1;
      kind <= k;
      data <= sd;
      qual <= sq;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      #1;
      snap = {frameEndMark, charDrop, frameAbort, sbValid, statusByte};
   endtask

   // One event, then interrupt, status and clear by read
   task automatic ev(input logic [2:0] k, input logic [7:0] sd, input logic [1:0] sq, input logic [31:0] st,
      input logic irq);
      send(k, sd, sq);
      @(posedge mclk);
      #1;
      chk("interrupt", {31'h0, irq}, {31'h0, hostInt});
      rdchk("status", OFS_STATUS, st);
      rdchk("status cleared", OFS_STATUS, 32'h0);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_total++;
      results();
   end

   initial begin
      term = 8'($random(seed));
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      rdchk("mask", OFS_MASK, 32'h000000ff);
      rdchk("config", OFS_CONFIG, 32'h0);
      rdchk("timeout", OFS_TIMEOUT, 32'h00000010);
      rdchk("lenlimit", OFS_LENLIMIT, 32'h00000100);
      rdchk("state", OFS_STATE, 32'h00000006);
      rdchk("unmapped", 8'h20, 32'h0);
      wr(OFS_TERMCHAR, {24'h0, term});
      wr(OFS_CONFIG, 32'h001);
      ev(3'd0, term, 2'b00, 32'h0, 1'b0);
      chk("frame end", 32'h1, {31'h0, snap[11]});
      wr(OFS_CONFIG, 32'h041);
      ev(3'd0, term, 2'b00, 32'h80, 1'b0);
      wr(OFS_MASK, 32'h0);
      wr(OFS_CONFIG, 32'h031);
      ev(3'd0, term, 2'b00, exp_char(2'b00, 1'b1), 1'b1);
      chk("frame end", 32'h1, {31'h0, snap[11]});
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         q = 2'($random(seed));
         if (d == term) d = d ^ 8'h01;
         ev(3'd0, d, q, exp_char(q, 1'b0), |q);
         chk("status byte", {23'h0, 1'b1, 6'h0, q}, {23'h0, snap[8:0]});
      end
      @(posedge mclk);
      fifoFull <= 1'b1;
      ev(3'd0, ~term, 2'b00, 32'h02, 1'b1);
      chk("char drop", 32'h1, {31'h0, snap[10]});
      // Status read in the very cycle of a dropped character: the new flag must survive
      fork
         send(3'd0, ~term, 2'b00);
         begin
            @(posedge mclk);
            rdchk("status", OFS_STATUS, 32'h0);
         end
      join
      rdchk("status", OFS_STATUS, 32'h02);
      @(posedge mclk);
      fifoFull <= 1'b0;
      carrier <= 1'b1;
      repeat (4) @(posedge mclk);
      rdchk("state", OFS_STATE, 32'h00000007);
      rdchk("status", OFS_STATUS, 32'h04);
      $display("test async done");
      wr(OFS_CONFIG, 32'h101);
      wr(OFS_TIMEOUT, 32'h2);
      ev(3'd0, ~term, 2'b00, 32'h0, 1'b0);
      repeat (800) @(posedge mclk);
      rdchk("status", OFS_STATUS, 32'h40);
      $display("test timeout done");
      wr(OFS_CONFIG, 32'h002);
      wr(OFS_COMMAND, 32'h1);
      rdchk("state", OFS_STATE, 32'h0000000f);
      ev(3'd1, 8'h00, 2'b00, 32'h10, 1'b1);
      // Sync character in the cycle right after the sync_search_command command
      fork
         wr(OFS_COMMAND, 32'h1);
         send(3'd1, 8'h00, 2'b00);
      join
      rdchk("status", OFS_STATUS, 32'h10);
      rdchk("state", OFS_STATE, 32'h00000007);
      $display("test bisync done");
      wr(OFS_CONFIG, 32'h000);
      ev(3'd2, 8'h00, 2'b00, 32'h40, 1'b1);
      wr(OFS_CONFIG, 32'h008);
      ev(3'd2, 8'h00, 2'b00, 32'h0, 1'b0);
      ev(3'd3, 8'h00, 2'b00, 32'h40, 1'b1);
      wr(OFS_CONFIG, 32'h004);
      ev(3'd4, 8'h00, 2'b00, 32'h0, 1'b0);
      ev(3'd4, 8'h00, 2'b01, 32'h20, 1'b1);
      rdchk("state", OFS_STATE, 32'h00000005);
      ev(3'd4, 8'h00, 2'b11, 32'h10, 1'b1);
      ev(3'd5, 8'h00, 2'b00, 32'h10, 1'b1);
      wr(OFS_CONFIG, 32'h000);
      fifoFull <= 1'b1;
      ev(3'd6, 8'h00, 2'b00, 32'h02, 1'b1);
      @(posedge mclk);
      fifoFull <= 1'b0;
      wr(OFS_CONFIG, 32'h080);
      wr(OFS_LENLIMIT, 32'h4);
      send(3'd2, 8'h00, 2'b00);
      for (int i = 0; i < 5; i++) begin
         send(3'd7, 8'h00, 2'b00);
         chk("abort", {31'h0, i == 4}, {31'h0, snap[9]});
      end
      rdchk("status", OFS_STATUS, 32'h41);
      $display("test hdlc done");
      wr(OFS_CONFIG, 32'he00);
      dpllLocked <= 1'b0;
      repeat (4) @(posedge mclk);
      rdchk("status", OFS_STATUS, 32'h08);
      chk("suspend", 32'h3, {30'h0, rxSuspend, txSuspend});
      @(posedge mclk);
      dpllLocked <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("suspend", 32'h0, {30'h0, rxSuspend, txSuspend});
      $display("test dpll done");
      results();
   end
endmodule // test_serial_channel_event_flags
`default_nettype wire
